// File: core/iramd_pkg.sv
package iramd_pkg;
  // Internal space layout
  localparam int unsigned IRAM_TOTAL_BYTES = 384;
  localparam logic [7:0] LOW_REGION_LAST = 8'h7F;
  localparam logic [7:0] BANK_AREA_LAST = 8'h1F;
  localparam logic [7:0] BIT_AREA_FIRST = 8'h20;
  localparam logic [7:0] BIT_AREA_LAST = 8'h2F;
  localparam logic [7:0] UPPER_REGION_FIRST = 8'h80;
  localparam int unsigned STACK_SPAN_BYTES = 256;
  localparam int unsigned SFR_SPAN_BYTES = 128;
  localparam int unsigned BANK_COUNT = 4;
  localparam int unsigned REGS_PER_BANK = 8;
  localparam int unsigned BIT_AREA_BITS = 128;
  localparam int unsigned BIT_SFR_COUNT = 16;
  // Bank-select field position in the status word
  localparam int unsigned PSW_BANK_LSB = 3;
  localparam logic [7:0] PSW_RESET = 8'h00;
  // Reset value of the read-data register
  localparam logic [7:0] RAM_RESET = 8'h00;
  // Access kinds issued by the core
  typedef enum logic [2:0] {
    IRAMD_DIRECT, IRAMD_INDIRECT, IRAMD_STACK, IRAMD_BIT, IRAMD_REG,
    IRAMD_EXT_DATA, IRAMD_EXT_PROG, IRAMD_IDLE
  } iramd_kind_t;
  // Bus phases on the inter-die link
  typedef enum logic [1:0] {
    IRAMD_BUS_IDLE, IRAMD_BUS_ADDR, IRAMD_BUS_DATA
  } iramd_bus_t;
endpackage

// File: core/iramd_ext_bus.sv
`timescale 1ns/1ps
// Inter-die bus engine: address phase then strobe phase
module iramd_ext_bus (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic is_prog_i,
  input wire logic is_write_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [15:0] bus_in_i,
  output logic [15:0] bus_out_o,
  output logic bus_oe_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic program_fetch_strobe_n_o,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] rdata_o
);
  iramd_pkg::iramd_bus_t state_reg, state_next;
  logic prog_reg, write_reg;
  logic [15:0] out_reg;
  logic [7:0] rdata_reg;
  logic [7:0] wdata_reg;
  logic done_reg;

  // Phase sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      iramd_pkg::IRAMD_BUS_IDLE: if (start_i) state_next = iramd_pkg::IRAMD_BUS_ADDR;
      iramd_pkg::IRAMD_BUS_ADDR: state_next = iramd_pkg::IRAMD_BUS_DATA;
      iramd_pkg::IRAMD_BUS_DATA: state_next = iramd_pkg::IRAMD_BUS_IDLE;
      default: state_next = iramd_pkg::IRAMD_BUS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= iramd_pkg::IRAMD_BUS_IDLE;
      prog_reg <= 1'b0;
      write_reg <= 1'b0;
      out_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg <= (state_reg == iramd_pkg::IRAMD_BUS_DATA);
      if (state_reg == iramd_pkg::IRAMD_BUS_IDLE && start_i) begin
        prog_reg <= is_prog_i;
        write_reg <= is_write_i && !is_prog_i;
        out_reg <= addr_i;
        wdata_reg <= wdata_i; // Store data taken with the request
      end else if (state_reg == iramd_pkg::IRAMD_BUS_ADDR) begin
        out_reg <= {8'h00, wdata_reg};
      end
      if (state_reg == iramd_pkg::IRAMD_BUS_DATA && !write_reg) rdata_reg <= bus_in_i[7:0];
    end
  end

  // Strobes: fetch uses its own strobe, data uses read/write
  wire in_data = (state_reg == iramd_pkg::IRAMD_BUS_DATA);
  assign ale_o = (state_reg == iramd_pkg::IRAMD_BUS_ADDR);
  assign program_fetch_strobe_n_o = !(in_data && prog_reg);
  assign rd_n_o = !(in_data && !prog_reg && !write_reg);
  assign wr_n_o = !(in_data && write_reg);
  assign bus_oe_n_o = !((state_reg == iramd_pkg::IRAMD_BUS_ADDR) || (in_data && write_reg));
  assign bus_out_o = out_reg;
  assign busy_o = (state_reg != iramd_pkg::IRAMD_BUS_IDLE) || start_i;
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
endmodule // iramd_ext_bus

// File: core/iramd_space_decoder.sv
`timescale 1ns/1ps
module iramd_space_decoder (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Core access port
  input wire logic req_i,
  input wire iramd_pkg::iramd_kind_t kind_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] psw_i,
  output logic ready_o,
  output logic rvalid_o,
  output logic [7:0] rdata_o,
  output logic ext_done_o,
  // Inter-die bus
  input wire logic [15:0] muxed_addr_data_bus_i,
  output logic [15:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe_n_o,
  output logic ale_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic program_fetch_strobe_n_o,
  output logic die_reset_n_o,
  // Debug gate and security bit
  input wire logic dbg_req_i,
  input wire logic sec_program_i,
  input wire logic full_erase_i,
  output logic dbg_grant_o,
  output logic sec_bit_o
);
  // Storage: low and upper RAM, and a separate special-register store
  logic [7:0] ram_mem [0:iramd_pkg::STACK_SPAN_BYTES-1];
  logic [7:0] sfr_mem [0:iramd_pkg::SFR_SPAN_BYTES-1];
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic sec_reg;
  logic die_rst_reg;

  // Bit address to byte address and bit position
  function automatic logic [7:0] bit_byte(input logic [7:0] baddr);
    if (baddr[7]) bit_byte = {baddr[7:3], 3'b000};
    else bit_byte = iramd_pkg::BIT_AREA_FIRST + {4'h0, baddr[6:3]};
  endfunction

  // Read-modify-write of one bit
  function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] pos,
                                           input logic val);
    logic [7:0] tmp;
    tmp = old;
    tmp[pos] = val;
    bit_merge = tmp;
  endfunction

  // Address decode
  wire [7:0] low_addr = addr_i[7:0];
  wire [1:0] bank_sel = psw_i[iramd_pkg::PSW_BANK_LSB +: 2];
  wire [7:0] reg_addr = {3'b000, bank_sel, addr_i[2:0]};
  wire is_upper = low_addr[7];
  wire k_direct = (kind_i == iramd_pkg::IRAMD_DIRECT);
  wire k_indir = (kind_i == iramd_pkg::IRAMD_INDIRECT) ||
                 (kind_i == iramd_pkg::IRAMD_STACK);
  wire k_bit = (kind_i == iramd_pkg::IRAMD_BIT);
  wire k_reg = (kind_i == iramd_pkg::IRAMD_REG);
  wire k_ext = (kind_i == iramd_pkg::IRAMD_EXT_DATA) ||
               (kind_i == iramd_pkg::IRAMD_EXT_PROG);
  wire [7:0] bit_addr = bit_byte(low_addr);
  // Direct above 7Fh goes to special registers, never upper RAM
  wire sel_sfr = (k_direct && is_upper) || (k_bit && is_upper);
  // Indirect and stack reach full 256 bytes of RAM
  wire sel_ram = (k_direct && !is_upper) || k_indir || k_reg || (k_bit && !is_upper);
  wire [7:0] ram_idx = k_reg ? reg_addr : (k_bit ? bit_addr : low_addr);
  wire [6:0] sfr_idx = k_bit ? bit_addr[6:0] : low_addr[6:0];
  wire [7:0] ram_old = ram_mem[ram_idx];
  wire [7:0] sfr_old = sfr_mem[sfr_idx];
  wire [7:0] byte_old = sel_sfr ? sfr_old : ram_old;
  wire [7:0] byte_new = k_bit ? bit_merge(byte_old, low_addr[2:0], wdata_i[0]) : wdata_i;
  wire int_req = req_i && !k_ext && (sel_ram || sel_sfr);
  wire int_wr = int_req && we_i;

  // External bus engine; only external kinds start it
  logic ext_busy, ext_done;
  logic [7:0] ext_rdata;
  wire ext_start = req_i && k_ext;
  iramd_ext_bus u_ext (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(ext_start),
    .is_prog_i(kind_i == iramd_pkg::IRAMD_EXT_PROG),
    .is_write_i(we_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .bus_in_i(muxed_addr_data_bus_i),
    .bus_out_o(muxed_addr_data_bus_o),
    .bus_oe_n_o(muxed_addr_data_bus_oe_n_o),
    .ale_o(ale_o),
    .rd_n_o(rd_n_o),
    .wr_n_o(wr_n_o),
    .program_fetch_strobe_n_o(program_fetch_strobe_n_o),
    .busy_o(ext_busy),
    .done_o(ext_done),
    .rdata_o(ext_rdata)
  );

  // Internal storage writes
  always_ff @(posedge sys_clk_i) begin
    if (int_wr && sel_ram) ram_mem[ram_idx] <= byte_new;
    if (int_wr && sel_sfr) sfr_mem[sfr_idx] <= byte_new;
  end

  // Internal read data, one cycle after the request
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= iramd_pkg::RAM_RESET;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= (int_req && !we_i) || ext_done;
      if (int_req && !we_i) rdata_reg <= k_bit ? {7'h00, byte_old[low_addr[2:0]]} : byte_old;
      else if (ext_done) rdata_reg <= ext_rdata;
    end
  end

  // Security bit: stays set until a full erase or a core reset clears it; erase wins over set
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_reg <= 1'b0;
    end else if (full_erase_i) begin
      sec_reg <= 1'b0;
    end else if (sec_program_i) begin
      sec_reg <= 1'b1;
    end
  end

  // Reset line to the memory die, released one cycle after core reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) die_rst_reg <= 1'b0;
    else die_rst_reg <= 1'b1;
  end

  assign ready_o = !ext_busy;
  assign rvalid_o = rvalid_reg;
  assign rdata_o = rdata_reg;
  assign ext_done_o = ext_done;
  assign die_reset_n_o = die_rst_reg;
  assign dbg_grant_o = dbg_req_i && !sec_reg;
  assign sec_bit_o = sec_reg;
endmodule // iramd_space_decoder

// File: dv/iramd_mem_die.sv
`timescale 1ns/1ps
// Memory die: latches the address, answers loads and fetches, takes stores
module iramd_mem_die (
  input wire logic sys_clk_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic fetch_n_i,
  input wire logic [15:0] bus_i,
  output logic [15:0] bus_o
);
  logic [15:0] addr_reg = 16'h0000;
  logic [15:0] last_reg = 16'h0000;
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
  // Address latch and store on write strobe
  always @(posedge sys_clk_i) begin
    if (ale_i) addr_reg <= bus_i;
    if (!wr_n_i) mem[addr_reg[7:0]] <= bus_i[7:0];
    last_reg <= bus_o;
  end
  // Data space, separate program space, else a released bus that flips
  assign bus_o = !rd_n_i ? {8'h00, mem[addr_reg[7:0]]} :
    !fetch_n_i ? {8'h00, ~addr_reg[7:0]} : ~last_reg;
endmodule // iramd_mem_die

// File: dv/iramd_space_decoder_properties.sv
`timescale 1ns/1ps
// Core port and inter-die bus checks
module iramd_space_decoder_properties (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire iramd_pkg::iramd_kind_t kind_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic rvalid_o,
  input wire logic ext_done_o,
  input wire logic [15:0] muxed_addr_data_bus_o,
  input wire logic ale_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic program_fetch_strobe_n_o,
  input wire logic dbg_req_i,
  input wire logic full_erase_i,
  input wire logic dbg_grant_o,
  input wire logic sec_bit_o
);
  logic [1:0] busy_reg;
  logic [1:0] busy_next;
  // Accepted requests; an external transfer holds the engine two more edges
  wire prog = kind_i == iramd_pkg::IRAMD_EXT_PROG;
  wire ext = prog || kind_i == iramd_pkg::IRAMD_EXT_DATA;
  wire go = req_i && busy_reg == 2'h0;
  wire int_go = go && !ext && kind_i != iramd_pkg::IRAMD_IDLE;
  wire ext_go = go && ext;
  wire [2:0] strb = {program_fetch_strobe_n_o, rd_n_o, wr_n_o};
  wire [15:0] bo = muxed_addr_data_bus_o;
  assign busy_next = ext_go ? 2'h2 : busy_reg - {1'b0, busy_reg != 2'h0};
  // Busy tracker
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) busy_reg <= 2'h0;
    else busy_reg <= busy_next;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_INT_QUIET: assert property (int_go |=> strb == 3'h7 && !ale_o)
    else $error("strobe on internal access");
  AST_INT_READ: assert property (int_go && !we_i |=> rvalid_o)
    else $error("no internal read data");
  AST_EXT_ADDR: assert property (ext_go |=> ale_o && bo == $past(addr_i))
    else $error("address phase wrong");
  AST_FETCH: assert property (ext_go && prog |-> ##2 strb == 3'h3)
    else $error("fetch strobe wrong");
  AST_LOAD: assert property (ext_go && !prog && !we_i |-> ##2 strb == 3'h5)
    else $error("load strobe wrong");
  AST_STORE:
    assert property (ext_go && !prog && we_i |-> ##2 strb == 3'h6 && bo[7:0] == $past(wdata_i, 2))
    else $error("store phase wrong");
  AST_EXT_END: assert property (ext_go |-> ##3 ext_done_o ##1 rvalid_o)
    else $error("external end late");
  AST_DBG_GATE: assert property (dbg_grant_o == (dbg_req_i && !sec_bit_o))
    else $error("debug gate wrong");
  AST_ERASE: assert property (full_erase_i |=> !sec_bit_o)
    else $error("erase left bit set");
  cover property (ext_go && prog);
  cover property (ext_go && we_i);
  cover property (int_go && kind_i == iramd_pkg::IRAMD_BIT);
endmodule // iramd_space_decoder_properties
bind iramd_space_decoder iramd_space_decoder_properties u_iramd_space_decoder_properties (
  .sys_clk_i, .rst_n_i, .req_i, .kind_i, .we_i, .addr_i, .wdata_i, .rvalid_o, .ext_done_o,
  .muxed_addr_data_bus_o, .ale_o, .rd_n_o, .wr_n_o, .program_fetch_strobe_n_o, .dbg_req_i,
  .full_erase_i, .dbg_grant_o, .sec_bit_o);

// File: dv/iramd_space_decoder_tb.sv
`timescale 1ns/1ps
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module iramd_space_decoder_tb;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b1, req_i = 1'b0, we_i = 1'b0;
  logic dbg_req_i = 1'b0, sec_program_i = 1'b0, full_erase_i = 1'b0;
  iramd_pkg::iramd_kind_t kind_i = iramd_pkg::IRAMD_IDLE;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, psw_i = 8'h00, rdata_o, got;
  logic ready_o, rvalid_o, ext_done_o, ale_o, rd_n_o, wr_n_o, program_fetch_strobe_n_o;
  logic die_reset_n_o, dbg_grant_o, sec_bit_o, muxed_addr_data_bus_oe_n_o;
  logic [15:0] muxed_addr_data_bus_o, die_bus;
  wire [15:0] bus = muxed_addr_data_bus_oe_n_o ? die_bus : muxed_addr_data_bus_o;
  wire [7:0] idle_view = {rd_n_o, wr_n_o, program_fetch_strobe_n_o,
    muxed_addr_data_bus_oe_n_o, ale_o, die_reset_n_o, sec_bit_o, rvalid_o};
  int errors = 0, checks_done = 0;
  // Rows: kind, write, address, write data, status word, expected byte
  logic [47:0] rows [24] = '{
    48'h01_0030_A5_00_00, 48'h10_0030_00_00_A5, 48'h11_0085_3C_00_00, 48'h01_0085_C3_00_00,
    48'h10_0085_00_00_3C, 48'h00_0085_00_00_C3, 48'h20_0085_00_00_3C, 48'h41_0003_77_10_00,
    48'h00_0013_00_00_77, 48'h41_0003_55_08_00, 48'h40_0003_00_10_77, 48'h00_000B_00_00_55,
    48'h01_0021_00_00_00, 48'h31_000A_01_00_00, 48'h00_0021_00_00_04, 48'h30_000A_00_00_01,
    48'h01_0088_00_00_00, 48'h31_0088_01_00_00, 48'h00_0088_00_00_01, 48'h51_0030_99_00_00,
    48'h50_0030_00_00_99, 48'h00_0030_00_00_A5, 48'h60_0030_00_00_CF, 48'h50_1234_00_00_6E};
  iramd_space_decoder u_iramd_space_decoder (.sys_clk_i, .rst_n_i, .req_i, .kind_i, .we_i,
    .addr_i, .bit_sel_i(3'h0), .wdata_i, .psw_i, .ready_o, .rvalid_o, .rdata_o, .ext_done_o,
    .muxed_addr_data_bus_i(bus), .muxed_addr_data_bus_o, .muxed_addr_data_bus_oe_n_o, .ale_o,
    .rd_n_o, .wr_n_o, .program_fetch_strobe_n_o, .die_reset_n_o, .dbg_req_i, .sec_program_i,
    .full_erase_i, .dbg_grant_o, .sec_bit_o);
  iramd_mem_die u_iramd_mem_die (.sys_clk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .fetch_n_i(program_fetch_strobe_n_o), .bus_i(bus), .bus_o(die_bus));
  // Verdict and end of run
  task automatic close_out();
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One core access; waits for read data or the external end
  task automatic access(input logic [3:0] k, input logic w, input logic [15:0] a,
      input logic [7:0] d, input logic [7:0] p);
    int n = 0;
    req_i = 1'b1;
    kind_i = iramd_pkg::iramd_kind_t'(k[2:0]);
    we_i = w;
    addr_i = a;
    wdata_i = d;
    psw_i = p;
    @(posedge sys_clk_i) #1;
    req_i = 1'b0;
    `CK(ready_o, k < 4'h5)
    while ((k > 4'h4 || !w) && rvalid_o !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i) #1;
      n++;
    end
    if (n == 8) begin
      errors++;
      close_out();
    end else begin
      got = rdata_o;
      `CK(ready_o, 1'b1)
      // Idle edge so the next call never raises the request in this time step
      @(posedge sys_clk_i) #1;
    end
  endtask
  initial forever #5 sys_clk_i = ~sys_clk_i;
  // Reset, row table, then the security gate
  initial begin
    logic [47:0] r;
    #2 rst_n_i = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    #1;
    `CK(idle_view, 8'hF0)
    rst_n_i = 1'b1;
    @(posedge sys_clk_i) #1;
    `CK(die_reset_n_o, 1'b1)
    foreach (rows[i]) begin
      r = rows[i];
      access(r[47:44], r[40], r[39:24], r[23:16], r[15:8]);
      if (!r[40] && i / 8 == 0) `CK(got, r[7:0])
      if (!r[40] && i / 8 == 1) `CK(got, r[7:0])
      if (!r[40] && i / 8 == 2) `CK(got, r[7:0])
    end
    dbg_req_i = 1'b1;
    sec_program_i = 1'b1;
    full_erase_i = 1'b1;
    @(posedge sys_clk_i) #1;
    `CK({sec_bit_o, dbg_grant_o}, 2'h1)
    full_erase_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1;
    `CK({sec_bit_o, dbg_grant_o}, 2'h2)
    sec_program_i = 1'b0;
    full_erase_i = 1'b1;
    @(posedge sys_clk_i) #1;
    `CK({sec_bit_o, dbg_grant_o}, 2'h1)
    // Reset in the middle of a fetch releases every strobe, then the bus works again
    full_erase_i = 1'b0;
    req_i = 1'b1;
    kind_i = iramd_pkg::IRAMD_EXT_PROG;
    @(posedge sys_clk_i) #1;
    req_i = 1'b0;
    @(posedge sys_clk_i) #1;
    `CK(program_fetch_strobe_n_o, 1'b0)
    rst_n_i = 1'b0;
    #1;
    `CK(idle_view, 8'hF0)
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    @(posedge sys_clk_i) #1;
    `CK({die_reset_n_o, rvalid_o, ready_o}, 3'h5)
    access(4'h6, 1'b0, 16'h0042, 8'h00, 8'h00);
    `CK(got, 8'hBD)
    close_out();
  end
endmodule // iramd_space_decoder_tb
